// File: verilog/gtf_pkg.sv
// Purpose : Shared constants for the timer and free-running counter block
// Assumes : 50 MHz hclk, AHB-Lite word access
// Notes   : Offsets are byte addresses within the block
package gtf_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CFG      = 12'h08C;
   localparam logic [11:0] OFS_CNT      = 12'h090;
   localparam logic [11:0] OFS_FREE     = 12'h09C;
   localparam logic [11:0] OFS_INT_STAT = 12'h0A0;
   localparam logic [11:0] OFS_INT_MASK = 12'h0A4;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          CFG_EN_BIT   = 29;
   localparam int          LOAD_W       = 16;
   localparam int          FR_W         = 32;
   localparam logic [15:0] LOAD_RST     = 16'hFFFF;
   localparam logic [15:0] LOAD_DIS     = 16'hFFFF;
   localparam logic [15:0] CNT_RST      = 16'hFFFF;
   localparam int          INT_W        = 2;
   localparam int          INT_TMR_BIT  = 0;
   localparam int          INT_WRAP_BIT = 1;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int HCLK_MHZ     = 50;
   localparam int FR_MHZ       = 25;
   localparam int HCLK_NS      = 1000 / HCLK_MHZ;
   localparam int FR_DIV       = HCLK_MHZ / FR_MHZ;
   localparam int FR_CLEAR_NS  = 160;
   // Longest time: round down
   localparam int FR_CLEAR_CYC = FR_CLEAR_NS / HCLK_NS;
   // ----------------------------------------------------------------
   // Bus slave states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WR    = 4'b0010,
      ST_RWAIT = 4'b0100,
      ST_RD    = 4'b1000
   } gtf_bus_state_type;
endpackage

// File: verilog/gtf_core_if.sv
// Purpose : Carries control and state between register file and counters
// Assumes : Single hclk domain
// Notes   : No logic inside
`timescale 1ns/100ps
interface gtf_core_if;
   logic        enable;
   logic [15:0] preload;
   logic [15:0] count;
   logic        expired;
   logic [31:0] fr_count;
   logic        fr_wrap;
   modport ctl (output enable, output preload, input count,
                input expired, input fr_count, input fr_wrap);
   modport tmr (input enable, input preload, output count,
                output expired);
   modport frc (output fr_count, output fr_wrap);
endinterface

// File: verilog/gtf_downcounter.sv
// Purpose : 16-bit down-counting interval timer
// Assumes : enable and preload come from the register file, same clock
// Notes   : Preload of zero gives an event on every cycle
`timescale 1ns/100ps
module gtf_downcounter
(
   // Clock and reset
   input  wire logic  hclk,
   input  wire logic  hresetn,
   // Register file side
   gtf_core_if.tmr    ifc
);
   logic en_q;

   // Remember enable to find the start of a run
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         en_q <= 1'b0;
      else
         en_q <= ifc.enable;
   end

   // Count: load on start, step down, reload at zero, hold when halted
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ifc.count   <= gtf_pkg::CNT_RST;
         ifc.expired <= 1'b0;
      end
      else
      begin
         ifc.expired <= 1'b0;
         if (ifc.enable && !en_q)
            ifc.count <= ifc.preload;
         else if (ifc.enable)
         begin
            if (ifc.count == 16'h0000)
            begin
               ifc.count   <= ifc.preload;
               ifc.expired <= 1'b1;
            end
            else
               ifc.count <= ifc.count - 16'h0001;
         end
      end
   end
endmodule

// File: verilog/gtf_freerun.sv
// Purpose : 32-bit free-running counter at 25 MHz
// Assumes : hclk is twice the counting rate
// Notes   : Wraps to zero and reports each wrap as a pulse
`timescale 1ns/100ps
module gtf_freerun
(
   // Clock and reset
   input  wire logic  hclk,
   input  wire logic  hresetn,
   // Register file side
   gtf_core_if.frc    ifc
);
   logic half;

   // Divide hclk by two to make the 25 MHz step
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         half <= 1'b0;
      else
         half <= ~half;
   end

   // Step and wrap; reset clears at once, well inside the allowed time
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ifc.fr_count <= 32'h00000000;
         ifc.fr_wrap  <= 1'b0;
      end
      else
      begin
         ifc.fr_wrap <= half && (ifc.fr_count == 32'hFFFFFFFF);
         if (half)
            ifc.fr_count <= ifc.fr_count + 32'h00000001;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_FR_STEP: assert property (
      $past(half) |-> ifc.fr_count == $past(ifc.fr_count) + 32'h00000001)
      else $error("free counter did not step");
   AST_FR_HOLD: assert property (
      !$past(half) && !$rose(hresetn) |-> $stable(ifc.fr_count))
      else $error("free counter stepped off its 25 MHz tick");
endmodule

// File: verilog/gtf_timer_top.sv
// Purpose : AHB-Lite slave with interval timer, free counter, interrupt
// Assumes : One slave on the bus, so hready is this slave's hreadyout
// Notes   : Writes take no wait state; reads take one
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps

// Functional notes
// - Timer runs while enable set, halts otherwise
// - Enable falling forces preload to all ones
// - Timer starts from preload and counts down
// - Enable is zero after reset
// - Timer interval can raise host interrupt
// - Read-only count field reads all ones after reset
// - Free counter starts zero, steps at 25 MHz
// - Free counter wraps to zero and continues
// - Free counter clear may take 160 ns
// - Free counter register shows live count
module gtf_timer_top
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // AHB-Lite slave
   input  wire logic         hsel,
   input  wire logic [11:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   // Interrupt
   output logic              irq
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   gtf_core_if                     ifc ();
   gtf_pkg::gtf_bus_state_type     state;
   gtf_pkg::gtf_bus_state_type     next_state;
   logic [11:0]                    addr_q;
   logic                           take;
   logic [gtf_pkg::INT_W-1:0]      int_status;
   logic [gtf_pkg::INT_W-1:0]      int_mask;
   logic [gtf_pkg::INT_W-1:0]      events;
   logic [gtf_pkg::INT_W-1:0]      w1c;
   logic                           wr_cfg;
   logic                           first;

   // Word match that ignores the byte lane bits
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   gtf_downcounter u_tmr
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ifc     (ifc.tmr)
   );

   gtf_freerun u_frc
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ifc     (ifc.frc)
   );

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // A transfer is taken only on a valid NONSEQ/SEQ with hready high;
   // hsize is not checked since the master only moves whole words
   assign take = hsel && htrans[1] && hready;

   // Next state of the transfer sequencer
   always_comb
   begin
      next_state = state;
      unique case (state)
         gtf_pkg::ST_IDLE, gtf_pkg::ST_WR, gtf_pkg::ST_RD:
         begin
            if (take)
               next_state = hwrite ? gtf_pkg::ST_WR : gtf_pkg::ST_RWAIT;
            else
               next_state = gtf_pkg::ST_IDLE;
         end
         gtf_pkg::ST_RWAIT:
            next_state = gtf_pkg::ST_RD;
         default:
            next_state = gtf_pkg::ST_IDLE;
      endcase
   end

   // Sequencer state and captured address
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state  <= gtf_pkg::ST_IDLE;
         addr_q <= 12'h000;
      end
      else
      begin
         state <= next_state;
         if (take)
            addr_q <= haddr;
      end
   end

   // Ready drops for the read wait; response is always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= (next_state != gtf_pkg::ST_RWAIT);
         hresp     <= 1'b0;
      end
   end

   // Read data is fetched in the wait cycle, so a read that follows a
   // write sees the written value; unmapped words read as zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (state == gtf_pkg::ST_RWAIT)
      begin
         hrdata <= 32'h00000000;
         if (hit(addr_q, gtf_pkg::OFS_CFG))
         begin
            hrdata[gtf_pkg::CFG_EN_BIT] <= ifc.enable;
            hrdata[15:0]                <= ifc.preload;
         end
         else if (hit(addr_q, gtf_pkg::OFS_CNT))
            hrdata[15:0] <= ifc.count;
         else if (hit(addr_q, gtf_pkg::OFS_FREE))
            hrdata <= ifc.fr_count;
         else if (hit(addr_q, gtf_pkg::OFS_INT_STAT))
            hrdata[gtf_pkg::INT_W-1:0] <= int_status;
         else if (hit(addr_q, gtf_pkg::OFS_INT_MASK))
            hrdata[gtf_pkg::INT_W-1:0] <= int_mask;
      end
   end

   // ----------------------------------------------------------------
   // Timer configuration
   // ----------------------------------------------------------------
   assign wr_cfg = (state == gtf_pkg::ST_WR) && hit(addr_q, gtf_pkg::OFS_CFG);

   // Only enable and preload are stored; all other bits are dropped
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ifc.enable  <= 1'b0;
         ifc.preload <= gtf_pkg::LOAD_RST;
      end
      else if (wr_cfg)
      begin
         ifc.enable <= hwdata[gtf_pkg::CFG_EN_BIT];
         // A stop write wins over the preload value written with it
         if (ifc.enable && !hwdata[gtf_pkg::CFG_EN_BIT])
            ifc.preload <= gtf_pkg::LOAD_DIS;
         else
            ifc.preload <= hwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   assign events = {ifc.fr_wrap, ifc.expired};
   assign w1c = ((state == gtf_pkg::ST_WR) &&
                 hit(addr_q, gtf_pkg::OFS_INT_STAT)) ?
                hwdata[gtf_pkg::INT_W-1:0] : '0;

   // Sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_status <= '0;
      else
         int_status <= (int_status & ~w1c) | events;
   end

   // Mask register; a one lets the matching status reach irq
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_mask <= '0;
      else if ((state == gtf_pkg::ST_WR) &&
               hit(addr_q, gtf_pkg::OFS_INT_MASK))
         int_mask <= hwdata[gtf_pkg::INT_W-1:0];
   end

   // Registered level; lags status by one cycle to keep the pin clean
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(int_status & int_mask);
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Marks the first cycle after reset release for the checks below
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         first <= 1'b1;
      else
         first <= 1'b0;
   end

   // All checks run on hclk and drop out while reset is held; the first
   // flag keeps history terms from treating reset values as a halt
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Timer run, halt, start and reload
   AST_HALT_HOLDS: assert property (
      !ifc.enable && $past(!ifc.enable) && !first |->
      $stable(ifc.count))
      else $error("halted timer count moved");
   // The second history term skips the load cycle that starts a run
   AST_RUN_STEPS: assert property (
      ifc.enable && $past(ifc.enable) && $past(ifc.enable, 2) &&
      $past(ifc.count) != 16'h0000 |->
      ifc.count == $past(ifc.count) - 16'h0001)
      else $error("running timer did not step down by one");
   AST_STOP_PRESET: assert property (
      $fell(ifc.enable) |-> ifc.preload == gtf_pkg::LOAD_DIS)
      else $error("preload not forced to all ones on stop");
   AST_START_LOAD: assert property (
      $rose(ifc.enable) |=> ifc.count == $past(ifc.preload))
      else $error("timer did not start from preload");
   AST_AFTER_RESET: assert property (
      first |-> !ifc.enable && ifc.count == gtf_pkg::CNT_RST)
      else $error("timer state wrong after reset");
   // A count left at zero by an earlier stop must not look like expiry
   AST_ZERO_RELOAD: assert property (
      ifc.enable && $past(ifc.enable) && $past(ifc.enable, 2) &&
      $past(ifc.count) == 16'h0000 |->
      ifc.expired && ifc.count == $past(ifc.preload))
      else $error("timer did not reload and flag at zero");
   AST_CFG_KEEP: assert property (
      !wr_cfg |=> $stable(ifc.enable) && $stable(ifc.preload))
      else $error("configuration changed without a write");
   AST_RO_WRITE: assert property (
      state == gtf_pkg::ST_WR && hit(addr_q, gtf_pkg::OFS_CNT) &&
      !ifc.enable |=> $stable(ifc.count))
      else $error("write to count register changed the count");

   // Free counter and read path
   AST_FR_CLEAR: assert property (
      first |-> ifc.fr_count < 32'(gtf_pkg::FR_CLEAR_CYC))
      else $error("free counter not cleared after reset");
   AST_FREE_READ: assert property (
      state == gtf_pkg::ST_RWAIT && hit(addr_q, gtf_pkg::OFS_FREE) |=>
      hrdata == $past(ifc.fr_count) && hreadyout)
      else $error("free counter read returned stale value");
   AST_CNT_READ: assert property (
      state == gtf_pkg::ST_RWAIT && hit(addr_q, gtf_pkg::OFS_CNT) |=>
      hrdata == {16'h0000, $past(ifc.count)} && hreadyout)
      else $error("count read returned wrong value");

   // Interrupt path; status keeps its bit until a one is written to it
   AST_STATUS_SET: assert property (
      ifc.expired |=> int_status[gtf_pkg::INT_TMR_BIT])
      else $error("timer event did not set status");
   AST_STATUS_CLEAR: assert property (
      w1c[gtf_pkg::INT_TMR_BIT] && !ifc.expired |=>
      !int_status[gtf_pkg::INT_TMR_BIT])
      else $error("status bit not cleared by a written one");
   AST_EVENT_IRQ: assert property (
      ifc.expired && int_mask[0] && w1c == '0 |=> ##1 irq)
      else $error("unmasked timer event did not raise irq");
   // The pin is one register behind the status and mask
   AST_IRQ_LEVEL: assert property (
      irq == $past(|(int_status & int_mask)))
      else $error("irq level does not follow masked status");

   // Main scenarios
   COV_EXPIRE: cover property (ifc.enable ##1 ifc.expired);
   COV_STOP: cover property ($fell(ifc.enable));
   COV_READ_CNT: cover property (state == gtf_pkg::ST_RWAIT &&
      hit(addr_q, gtf_pkg::OFS_CNT));
   COV_IRQ: cover property ($rose(irq));
   COV_CLEAR: cover property (w1c[gtf_pkg::INT_TMR_BIT] &&
      int_status[gtf_pkg::INT_TMR_BIT]);
endmodule

// File: tb/gtf_timer_top_test.sv
// Purpose : Self-checking bench for the timer and free counter block
// Assumes : One AHB-Lite master here, hready tied back to hreadyout
// Notes   : Free counter wrap needs 2^33 cycles, so it is not reached
`timescale 1ns/100ps
module gtf_timer_top_test;
   // ----------------------------------------------------------------
   // Signals and model state
   // ----------------------------------------------------------------
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        irq;
   int          mismatches;
   int          check_count;
   int          cyc;
   int          scyc;
   int          crel;
   int          c1;
   int          m_cfg;
   int          d;
   logic [31:0] lfsr_state;
   logic [31:0] v1;
   logic [31:0] v2;
   logic [15:0] pl;

   gtf_timer_top gtf_timer_top_i
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .irq       (irq)
   );

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   // 50 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // Cycle count, updated nonblocking so reads right after the edge see the old value
   always @(posedge hclk)
      cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One AHB-Lite single transfer; entered just after a rising edge and
   // left just after the edge that ends its data phase
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize  <= 3'b010;
      // Address phase stands until ready is seen high at an edge
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      // Data phase stands until ready is seen high again; data taken there
      do @(posedge hclk); while (hready !== 1'b1);
      rdv  = hrdata;
      scyc = cyc;
      check({31'h0, hresp}, 32'h00000000);
   endtask

   // Write that also updates the model of the configuration word
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] unused;
      if (a == gtf_pkg::OFS_CFG)
         m_cfg = (wd[29] ? 32'h20000000 : 32'h00000000) |
                 ((m_cfg[29] && !wd[29]) ? 32'h0000FFFF : {16'h0, wd[15:0]});
      xfer(1'b1, a, wd, unused);
   endtask

   // ----------------------------------------------------------------
   // Watchdog: tests need a few hundred cycles at most
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      $display("timeout at %0t", $time);
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      hresetn     = 1'b0;
      hsel        = 1'b0;
      haddr       = 12'h000;
      htrans      = 2'b00;
      hwrite      = 1'b0;
      hsize       = 3'b010;
      hwdata      = 32'h00000000;
      cyc         = 0;
      mismatches  = 0;
      check_count = 0;
      m_cfg       = 32'h0000FFFF;
      lfsr_state  = 32'hA29BD7C6;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      crel = cyc;
      // Reset values, unmapped word reads zero
      xfer(1'b0, gtf_pkg::OFS_CFG, 32'h0, v1);
      check(v1, 32'h0000FFFF);
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v1);
      check(v1, 32'h0000FFFF);
      xfer(1'b0, gtf_pkg::OFS_INT_MASK, 32'h0, v1);
      check(v1, 32'h00000000);
      xfer(1'b0, 12'h000, 32'h0, v1);
      check(v1, 32'h00000000);
      $display("test reset values done");
      // Free counter: live, half the bus rate, writes ignored
      xfer(1'b0, gtf_pkg::OFS_FREE, 32'h0, v1);
      c1 = scyc;
      check(32'(v1 <= (c1 - crel) / 2 + 1), 32'h1);
      repeat (3)
      begin
         lfsr_state = lfsr(lfsr_state);
         wr(gtf_pkg::OFS_FREE, lfsr_state);
         repeat (lfsr_state[4:0]) @(posedge hclk);
         xfer(1'b0, gtf_pkg::OFS_FREE, 32'h0, v2);
         d = int'(v2 - v1) * 2 - (scyc - c1);
         check(32'(d >= -1 && d <= 1), 32'h1);
         v1 = v2;
         c1 = scyc;
      end
      $display("test free counter done");
      // Timer runs down from a random preload, then halts on stop
      lfsr_state = lfsr(lfsr_state);
      wr(gtf_pkg::OFS_CFG, {16'h2000, 1'b1, lfsr_state[14:0]});
      c1 = scyc;
      pl = m_cfg[15:0];
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v1);
      check(32'(v1[15:0] <= pl && pl - v1[15:0] <= scyc - c1), 32'h1);
      c1 = scyc;
      repeat (lfsr_state[20:16]) @(posedge hclk);
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v2);
      check(v1 - v2, 32'(scyc - c1));
      wr(gtf_pkg::OFS_CFG, 32'h00001234);
      xfer(1'b0, gtf_pkg::OFS_CFG, 32'h0, v1);
      check(v1, 32'(m_cfg));
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v1);
      repeat (8) @(posedge hclk);
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v2);
      check(v1 - v2, 32'h00000000);
      // Reserved bits and the count register ignore writes
      wr(gtf_pkg::OFS_CFG, {16'hDFFF, lfsr_state[15:0]});
      wr(gtf_pkg::OFS_CNT, 32'hFFFF0000);
      xfer(1'b0, gtf_pkg::OFS_CFG, 32'h0, v1);
      check(v1, 32'(m_cfg));
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v1);
      check(v1, v2);
      $display("test timer run and stop done");
      // Short interval: event, reload, masked then unmasked irq
      wr(gtf_pkg::OFS_INT_MASK, 32'h0);
      pl = {12'h000, lfsr_state[23:20]} + 16'h0002;
      wr(gtf_pkg::OFS_CFG, {16'h2000, pl});
      repeat (40) @(posedge hclk);
      xfer(1'b0, gtf_pkg::OFS_CNT, 32'h0, v1);
      check(32'(v1[15:0] <= pl), 32'h1);
      xfer(1'b0, gtf_pkg::OFS_INT_STAT, 32'h0, v1);
      check(v1, 32'h00000001);
      check({31'h0, irq}, 32'h00000000);
      wr(gtf_pkg::OFS_INT_MASK, 32'h1);
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      check({31'h0, irq}, 32'h00000001);
      @(posedge hclk);
      wr(gtf_pkg::OFS_CFG, 32'h00000000);
      repeat (4) @(posedge hclk);
      wr(gtf_pkg::OFS_INT_STAT, 32'h1);
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      check({31'h0, irq}, 32'h00000000);
      @(posedge hclk);
      xfer(1'b0, gtf_pkg::OFS_INT_STAT, 32'h0, v1);
      check(v1, 32'h00000000);
      $display("test timer interrupt done");
      results();
   end
endmodule
